// file: verilog/dpwc_map.svh
`ifndef DPWC_MAP_SVH
`define DPWC_MAP_SVH
// ==========================================================
// wiper code constants
`define DPWC_MIDSCALE 8'h80
`define DPWC_ZERO_CODE 8'h00
`define DPWC_TAPS 256
// ==========================================================
// serial slave addressing and instruction fields
`define DPWC_ADDR_HI 6'h16
`define DPWC_MID_RST_BIT 6
`define DPWC_SHUTDOWN_BIT 5
`define DPWC_BYTE_BITS 4'h8
// ==========================================================
// controller frame layout: bit slots, ack check masks
`define DPWC_WR_SLOTS 5'h1B
`define DPWC_RD_SLOTS 5'h12
`define DPWC_SPI_SLOTS 5'h08
`define DPWC_WR_CHECK 27'h0040201
`define DPWC_RD_CHECK 27'h0040000
// ==========================================================
// controller register map (byte addresses)
`define DPWC_REG_CTRL 8'h00
`define DPWC_REG_CFG 8'h04
`define DPWC_REG_STAT 8'h08
// ==========================================================
// link timing: bit period made by the controller divider
`define DPWC_REF_PERIOD_NS 5
`define DPWC_LINK_PERIOD_NS 50
`define DPWC_HALF_CYCLES \
  ((`DPWC_LINK_PERIOD_NS / `DPWC_REF_PERIOD_NS) / 2)
`endif

// file: verilog/dpwc_pkg.sv
// ==========================================================
// shared state types
package dpwc_pkg;
  // serial slave states of the device end
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_INSTR, S_DATA, S_ACK, S_SEND, S_RACK
  } dpwc_slave_type;
  // bit sequencer states of the controller end
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_LOWER, H_SETUP, H_HIGH, H_FALL, H_STOPA, H_STOPB
  } dpwc_host_type;
endpackage : dpwc_pkg

// file: verilog/dpwc_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// link between controller and potentiometer
interface dpwc_if;
  logic sel; // interface select strap, high = two-wire bus
  logic cs_n; // chip select, or address select level
  logic clk; // serial clock, made by the controller
  logic host_sda_o; // controller data value
  logic host_sda_oe_n; // controller drives data line when low
  logic dev_sda_o; // device data value
  logic dev_sda_oe_n; // device drives data line when low
  logic sda; // resolved data line, pulled up when nobody drives
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport host (output sel, output cs_n, output clk, output host_sda_o,
    output host_sda_oe_n, input sda);
  modport device (input sel, input cs_n, input clk, input sda,
    output dev_sda_o, output dev_sda_oe_n);
endinterface : dpwc_if
`default_nettype wire

// file: verilog/dpwc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-stage synchroniser for pins from outside the clock
module dpwc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // first stage, read only by q
  // reset value matches the idle level of each pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : dpwc_sync
`default_nettype wire

// file: verilog/dpwc_device.sv
// Contract
// R1: select pin low picks SPI, high picks two-wire
// R2: wiper powers up at midscale
// R3: each 8-bit code selects one tap
// R4: code zero at B, each step toward A
// R5: topmost segment is never reached
// R6: wiper-to-A resistance is complementary
// R7: reset bit forces midscale code 80 hex
// R8: shutdown opens A, wiper to B, keeps code
// R9: write frame: address, instruction, data, acked
// R10: read frame returns wiper after address ack
// R11: SPI word is eight bits, MSB first
// R12: shift data on clock rise while selected
// R13: chip select rise loads wiper register
// R14: extra bits drop the earliest ones
// R15: address is fixed six bits plus pin
// R16: instruction bit 6 reset, bit 5 shutdown
// R17: codes accepted in shutdown, applied after
// R18: further data bytes reuse the instruction
// R19: other addresses are ignored, never acked
// R20: shutdown output follows last instruction bit
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "dpwc_map.svh"
`default_nettype none
module dpwc_device #(
  parameter int TAPS = `DPWC_TAPS
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CE,
  dpwc_if.device LINK,
  output logic [7:0] WIPER_REG,
  output logic [7:0] TAP_INDEX,
  output logic [TAPS-1:0] TAP_SEL,
  output logic [8:0] RWB_STEPS,
  output logic [8:0] RWA_STEPS,
  output logic A_OPEN,
  output logic SHUTDOWN
);
  // ==========================================================
  // tap decoding
  // one-hot tap select; the code range stops at TAPS-1
  function automatic logic [TAPS-1:0] tap_onehot(input logic [7:0] code);
    tap_onehot = '0;
    tap_onehot[code] = 1'h1; // R3 R5
  endfunction : tap_onehot

  // ==========================================================
  // pin synchronisation and edge detection
  logic [3:0] pin_raw; // sel, cs_n, clk, sda
  logic [3:0] pin_s; // synchronised pins
  logic [3:0] prev_q; // pins one cycle older
  assign pin_raw = {LINK.sel, LINK.cs_n, LINK.clk, LINK.sda};

  dpwc_sync #(.W(4), .INIT(4'h7)) u_sync (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .ce(CE),
    .d(pin_raw),
    .q(pin_s)
  );

  // previous samples feed the edge detectors
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) prev_q <= 4'h7;
    else if (CE) prev_q <= pin_s;
  end

  wire i2c_mode = pin_s[3]; // R1
  wire cs_lvl = pin_s[2]; // chip select, or address pin level
  wire clk_rise = pin_s[1] & ~prev_q[1];
  wire clk_fall = ~pin_s[1] & prev_q[1];
  wire clk_held = pin_s[1] & prev_q[1]; // clock high both samples
  wire sda_in = pin_s[0];
  // start and stop: data moves while the clock stays high
  wire bus_start = i2c_mode & clk_held & ~pin_s[0] & prev_q[0];
  wire bus_stop = i2c_mode & clk_held & pin_s[0] & ~prev_q[0];

  // ==========================================================
  // three-wire port
  logic [7:0] shift_q; // serial input register
  wire spi_shift = ~i2c_mode & ~cs_lvl & clk_rise; // R1 R12
  wire spi_load = ~i2c_mode & cs_lvl & ~prev_q[2]; // R13

  // shifting left keeps only the last eight bits
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) shift_q <= `DPWC_ZERO_CODE;
    else if (CE && spi_shift) shift_q <= {shift_q[6:0], sda_in}; // R11 R14
  end

  // ==========================================================
  // two-wire slave
  dpwc_pkg::dpwc_slave_type state_q; // protocol state
  dpwc_pkg::dpwc_slave_type next_q; // state after the ack slot
  logic [3:0] cnt_q; // bits seen in the current byte
  logic [7:0] byte_q; // received byte
  logic [7:0] tx_q; // byte being returned
  logic oe_n_q; // data line pulled low when clear
  logic mid_rst_q; // reset bit of the active instruction
  logic shutdown_q; // shutdown bit of the last instruction
  logic mack_q; // controller acked the returned byte

  wire rx_state = (state_q == dpwc_pkg::S_ADDR) |
    (state_q == dpwc_pkg::S_INSTR) | (state_q == dpwc_pkg::S_DATA);
  // a byte ends on the clock fall after its eighth bit
  wire byte_done = rx_state & clk_fall & (cnt_q == `DPWC_BYTE_BITS);
  wire addr_ok = byte_q[7:1] == {`DPWC_ADDR_HI, cs_lvl}; // R15
  wire instr_done = byte_done & (state_q == dpwc_pkg::S_INSTR);
  wire data_done = byte_done & (state_q == dpwc_pkg::S_DATA);

  // leaving the two-wire mode or a stop always frees the line
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= dpwc_pkg::S_IDLE;
      next_q <= dpwc_pkg::S_IDLE;
      cnt_q <= 4'h0;
      byte_q <= 8'h00;
      tx_q <= 8'h00;
      oe_n_q <= 1'h1;
      mid_rst_q <= 1'h0;
      mack_q <= 1'h0;
    end else if (CE) begin
      if (!i2c_mode || bus_stop) begin
        state_q <= dpwc_pkg::S_IDLE;
        oe_n_q <= 1'h1;
      end else if (bus_start) begin
        // a repeated start also restarts here
        state_q <= dpwc_pkg::S_ADDR;
        cnt_q <= 4'h0;
        oe_n_q <= 1'h1;
      end else begin
        unique case (state_q)
          // wait for a start condition
          dpwc_pkg::S_IDLE: ;
          dpwc_pkg::S_ADDR, dpwc_pkg::S_INSTR, dpwc_pkg::S_DATA: begin
            if (clk_rise) begin
              byte_q <= {byte_q[6:0], sda_in};
              cnt_q <= cnt_q + 4'h1;
            end else if (byte_done) begin
              cnt_q <= 4'h0;
              if (state_q != dpwc_pkg::S_ADDR) begin
                // instruction or data byte: always acked
                oe_n_q <= 1'h0; // R9
                state_q <= dpwc_pkg::S_ACK;
                next_q <= dpwc_pkg::S_DATA; // R18
                if (instr_done) mid_rst_q <= byte_q[`DPWC_MID_RST_BIT]; // R16
              end else if (addr_ok) begin
                oe_n_q <= 1'h0; // R9
                state_q <= dpwc_pkg::S_ACK;
                // read goes straight to data, write to instruction
                next_q <= byte_q[0] ? dpwc_pkg::S_SEND :
                  dpwc_pkg::S_INSTR; // R10
              end else begin
                state_q <= dpwc_pkg::S_IDLE; // R19
              end
            end
          end
          // release ack at the end of the ninth clock
          dpwc_pkg::S_ACK: begin
            if (clk_fall) begin
              state_q <= next_q;
              tx_q <= WIPER_REG;
              oe_n_q <= (next_q == dpwc_pkg::S_SEND) ? WIPER_REG[7] :
                1'h1; // R10
            end
          end
          // return the wiper code, msb first
          dpwc_pkg::S_SEND: begin
            if (clk_fall) begin
              if (cnt_q == 4'h7) begin
                oe_n_q <= 1'h1;
                cnt_q <= 4'h0;
                state_q <= dpwc_pkg::S_RACK;
              end else begin
                oe_n_q <= tx_q[6];
                tx_q <= {tx_q[6:0], 1'h0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          // an ack from the controller asks for one more byte
          dpwc_pkg::S_RACK: begin
            if (clk_rise) mack_q <= ~sda_in;
            else if (clk_fall) begin
              if (mack_q) begin
                state_q <= dpwc_pkg::S_SEND;
                tx_q <= WIPER_REG;
                oe_n_q <= WIPER_REG[7]; // R10
              end else begin
                state_q <= dpwc_pkg::S_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  assign LINK.dev_sda_o = 1'h0; // open drain: only ever pulls low
  assign LINK.dev_sda_oe_n = oe_n_q;

  // ==========================================================
  // wiper register and shutdown
  logic [7:0] wiper_q; // stored wiper code
  logic [7:0] wiper_d;
  logic shutdown_d;
  logic [7:0] applied_d; // code seen by the ladder

  // reset bit overrides data, and keeps doing so for this frame
  assign wiper_d = spi_load ? shift_q : // R13
    (instr_done && byte_q[`DPWC_MID_RST_BIT]) ? `DPWC_MIDSCALE : // R7
    data_done ? (mid_rst_q ? `DPWC_MIDSCALE : byte_q) : wiper_q; // R9 R18
  assign shutdown_d = instr_done ? byte_q[`DPWC_SHUTDOWN_BIT] : // R16 R20
    shutdown_q;
  // shutdown puts the wiper on B but leaves the code alone
  assign applied_d = shutdown_d ? `DPWC_ZERO_CODE : wiper_d; // R8 R17

  // codes keep loading during shutdown
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wiper_q <= `DPWC_MIDSCALE; // R2
      shutdown_q <= 1'h0;
    end else if (CE) begin
      wiper_q <= wiper_d; // R17
      shutdown_q <= shutdown_d; // R20
    end
  end

  // ==========================================================
  // ladder outputs, registered
  logic [7:0] tap_q; // applied tap, 0 is the B terminal
  logic [TAPS-1:0] tap_sel_q; // one-hot tap switch
  logic [8:0] rwa_q; // segments between wiper and A

  // wiper-to-A counts the remaining segments down from TAPS
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tap_q <= `DPWC_MIDSCALE; // R2
      tap_sel_q <= tap_onehot(`DPWC_MIDSCALE);
      rwa_q <= 9'(TAPS) - {1'h0, `DPWC_MIDSCALE};
    end else if (CE) begin
      tap_q <= applied_d; // R4
      tap_sel_q <= tap_onehot(applied_d); // R3
      rwa_q <= 9'(TAPS) - {1'h0, applied_d}; // R6
    end
  end

  assign WIPER_REG = wiper_q;
  assign TAP_INDEX = tap_q;
  assign TAP_SEL = tap_sel_q;
  assign RWB_STEPS = {1'h0, tap_q}; // R4
  assign RWA_STEPS = rwa_q;
  assign A_OPEN = shutdown_q; // R8
  assign SHUTDOWN = shutdown_q; // R20
endmodule : dpwc_device
`default_nettype wire

// file: verilog/dpwc_host.sv
`timescale 1ns/1ps
`include "dpwc_map.svh"
`default_nettype none
// ==========================================================
// controller: APB registers drive one frame at a time
module dpwc_host #(
  parameter int HALF_CYCLES = `DPWC_HALF_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CE,
  dpwc_if.host LINK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  // ==========================================================
  // register access
  logic [1:0] cfg_q; // bit 0 select, bit 1 address pin level
  logic [7:0] instr_q; // instruction byte
  logic [7:0] data_q; // data byte
  logic rd_q; // next two-wire frame reads back
  logic [7:0] rdata_q; // last read-back code
  logic nack_q; // a slot expected an ack and saw none
  logic [31:0] prdata_q;
  dpwc_pkg::dpwc_host_type state_q;

  wire busy = state_q != dpwc_pkg::H_IDLE;
  wire hit_ctrl = PADDR == `DPWC_REG_CTRL;
  wire hit_cfg = PADDR == `DPWC_REG_CFG;
  wire hit_stat = PADDR == `DPWC_REG_STAT;
  wire hit_any = hit_ctrl | hit_cfg | hit_stat;
  wire wr = PSEL & PENABLE & PWRITE;
  // writes while a frame runs are dropped, so the link stays coherent
  wire wr_ok = wr & ~busy;
  wire go = wr_ok & hit_ctrl & PWDATA[0];
  wire [31:0] rd_val = hit_ctrl ? {8'h00, instr_q, data_q, 6'h00, rd_q,
    1'h0} : hit_cfg ? {30'h0, cfg_q} :
    hit_stat ? {16'h0000, rdata_q, 6'h00, nack_q, busy} : 32'h0;

  // read data is captured in the setup cycle, ready in access
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_q <= 2'h0;
      instr_q <= 8'h00;
      data_q <= 8'h00;
      rd_q <= 1'h0;
      prdata_q <= 32'h0;
    end else if (CE) begin
      if (PSEL && !PENABLE) prdata_q <= rd_val;
      if (wr_ok && hit_cfg) cfg_q <= PWDATA[1:0];
      if (wr_ok && hit_ctrl) begin
        rd_q <= PWDATA[1];
        data_q <= PWDATA[15:8];
        instr_q <= PWDATA[23:16];
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = 1'h1;
  assign PSLVERR = PSEL & PENABLE & ~hit_any;

  // ==========================================================
  // frame contents: one bit per slot; in two-wire a 1 releases the line, in three-wire a 1 drives it high
  wire rd_now = PWDATA[1];
  // ctrl bit 2 flips the pin bit to reach the other device on the bus
  wire [6:0] addr7 = {`DPWC_ADDR_HI, cfg_q[1] ^ PWDATA[2]}; // R15
  wire [26:0] wr_frame = {addr7, 1'h0, 1'h1, PWDATA[23:16], 1'h1,
    PWDATA[15:8], 1'h1}; // R9
  wire [26:0] rd_frame = {addr7, 1'h1, 1'h1, 8'hFF, 1'h1, 9'h1FF}; // R10
  wire [26:0] spi_frame = {PWDATA[15:8], 19'h0}; // R11

  // ==========================================================
  // bit sequencer
  logic [15:0] tmr_q; // state-step divider
  logic [4:0] slot_q; // current slot
  logic [4:0] len_q; // slots in this frame
  logic [26:0] frame_q; // slots still to send
  logic [26:0] check_q; // slots that must read low
  logic [8:0] rx_q; // last nine sampled slots
  logic scl_q;
  logic cs_q;
  logic sda_o_q;
  logic sda_oe_n_q;
  logic sda_s; // synchronised data line

  dpwc_sync #(.W(1), .INIT(1'h1)) u_sync (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .ce(CE),
    .d(LINK.sda),
    .q(sda_s)
  );

  wire tick = tmr_q == 16'h0;
  wire i2c = cfg_q[0];

  // one state step every HALF_CYCLES cycles; each bit slot spans three steps (clock high one, low two)
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= dpwc_pkg::H_IDLE;
      tmr_q <= 16'h0;
      slot_q <= 5'h00;
      len_q <= 5'h00;
      frame_q <= 27'h0;
      check_q <= 27'h0;
      rx_q <= 9'h000;
      scl_q <= 1'h0;
      cs_q <= 1'h1;
      sda_o_q <= 1'h1;
      sda_oe_n_q <= 1'h1;
      nack_q <= 1'h0;
      rdata_q <= 8'h00;
    end else if (CE) begin
      tmr_q <= (tick || go) ? 16'(HALF_CYCLES - 1) : tmr_q - 16'h1;
      if (go) begin
        nack_q <= 1'h0;
        slot_q <= 5'h00;
        frame_q <= !i2c ? spi_frame : rd_now ? rd_frame : wr_frame;
        check_q <= !i2c ? 27'h0 : rd_now ? `DPWC_RD_CHECK : `DPWC_WR_CHECK;
        len_q <= !i2c ? `DPWC_SPI_SLOTS : rd_now ? `DPWC_RD_SLOTS :
          `DPWC_WR_SLOTS;
        cs_q <= i2c; // R1
        state_q <= i2c ? dpwc_pkg::H_START : dpwc_pkg::H_SETUP;
      end else if (!busy) begin
        // idle: clock rests high for two-wire, low for three-wire
        scl_q <= i2c;
      end else if (tick) begin
        unique case (state_q)
          dpwc_pkg::H_IDLE: ;
          // start: data falls while the clock is high
          dpwc_pkg::H_START: begin
            sda_o_q <= 1'h0;
            sda_oe_n_q <= 1'h0;
            state_q <= dpwc_pkg::H_LOWER;
          end
          dpwc_pkg::H_LOWER: begin
            scl_q <= 1'h0;
            state_q <= dpwc_pkg::H_SETUP;
          end
          // data changes only while the clock is low
          dpwc_pkg::H_SETUP: begin
            sda_o_q <= i2c ? 1'h0 : frame_q[26];
            sda_oe_n_q <= i2c ? frame_q[26] : 1'h0;
            state_q <= dpwc_pkg::H_HIGH;
          end
          dpwc_pkg::H_HIGH: begin
            scl_q <= 1'h1;
            state_q <= dpwc_pkg::H_FALL;
          end
          // sample at the end of the high phase, then lower clock
          dpwc_pkg::H_FALL: begin
            scl_q <= 1'h0;
            rx_q <= {rx_q[7:0], sda_s};
            if (check_q[26] && sda_s) nack_q <= 1'h1;
            frame_q <= {frame_q[25:0], 1'h1};
            check_q <= {check_q[25:0], 1'h0};
            slot_q <= slot_q + 5'h01;
            state_q <= (slot_q == len_q - 5'h01) ? dpwc_pkg::H_STOPA :
              dpwc_pkg::H_SETUP;
          end
          // three-wire ends with chip select high; two-wire pulls low
          dpwc_pkg::H_STOPA: begin
            if (i2c) begin
              sda_o_q <= 1'h0;
              sda_oe_n_q <= 1'h0;
              state_q <= dpwc_pkg::H_STOPB;
            end else begin
              cs_q <= 1'h1;
              sda_oe_n_q <= 1'h1;
              state_q <= dpwc_pkg::H_IDLE;
            end
          end
          // stop: clock high, then data released on the next step
          dpwc_pkg::H_STOPB: begin
            if (!scl_q) scl_q <= 1'h1;
            else begin
              sda_oe_n_q <= 1'h1;
              sda_o_q <= 1'h1;
              if (rd_q) rdata_q <= rx_q[8:1];
              state_q <= dpwc_pkg::H_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign LINK.sel = cfg_q[0]; // R1
  // in two-wire mode the shared pin carries the address level
  assign LINK.cs_n = i2c ? cfg_q[1] : cs_q;
  assign LINK.clk = scl_q;
  assign LINK.host_sda_o = sda_o_q;
  assign LINK.host_sda_oe_n = sda_oe_n_q;
endmodule : dpwc_host
`default_nettype wire

// file: test/dpwc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// link and wiper properties, watched beside the link
module dpwc_properties #(
  parameter int TAPS = 256
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic sel,
  input wire logic cs_n,
  input wire logic clk,
  input wire logic dev_sda_oe_n,
  input wire logic [7:0] WIPER_REG,
  input wire logic [7:0] TAP_INDEX,
  input wire logic [TAPS-1:0] TAP_SEL,
  input wire logic [8:0] RWB_STEPS,
  input wire logic [8:0] RWA_STEPS,
  input wire logic A_OPEN,
  input wire logic SHUTDOWN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  logic [3:0] cs_age_q; // cycles since chip select was last low
  // ==========================================================
  // chip select age; saturates so a long idle never wraps
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cs_age_q <= 4'hF;
    end else if (!cs_n) begin
      cs_age_q <= 4'h0;
    end else if (cs_age_q != 4'hF) begin
      cs_age_q <= cs_age_q + 4'h1;
    end
  end
  // ==========================================================
  // tap decode and resistance steps
  a_tap_one_hot: assert property (TAP_SEL == (TAPS'(1) << TAP_INDEX))
    else $error("tap select is not one-hot of the tap index");
  a_rwb_tracks_tap: assert property (!SHUTDOWN |->
    RWB_STEPS == {1'b0, WIPER_REG})
    else $error("low-side steps differ from the stored code");
  a_rwa_complement: assert property (RWA_STEPS + RWB_STEPS == 9'h100)
    else $error("high-side steps are not complementary");
  a_top_unused: assert property (RWA_STEPS != 9'h000)
    else $error("wiper reached the topmost segment");
  // ==========================================================
  // shutdown grounds the wiper and opens the high end
  a_open_wiper_low: assert property (A_OPEN |-> RWB_STEPS == 9'h000)
    else $error("high terminal open but wiper not on low terminal");
  a_shutdown_grounds_tap: assert property (
    SHUTDOWN |-> TAP_INDEX == 8'h00)
    else $error("tap not grounded in shutdown");
  // ==========================================================
  // three-wire mode: load only after chip select, never drive data
  a_spi_load_cs: assert property (
    $changed(WIPER_REG) && !sel && !$past(sel, 8) |-> cs_age_q < 4'hC)
    else $error("wiper changed without a chip select rise");
  a_silent_in_spi: assert property (
    !sel && !$past(sel, 8) |-> dev_sda_oe_n)
    else $error("device drives data in three-wire mode");
  // data line from the device only moves while the clock is low
  a_data_clk_low: assert property (
    $changed(dev_sda_oe_n) |-> !clk)
    else $error("device data changed while clock high");
endmodule : dpwc_properties
`default_nettype wire

// file: test/digipot_serial_wiper_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench: APB orders the controller, device outputs checked
module digipot_serial_wiper_control_bench;
  logic REF_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, A_OPEN, SHUTDOWN, err;
  logic [7:0] WIPER_REG, TAP_INDEX, ins, code, wexp;
  logic [7:0] lfsr_q = 8'h22; // random source, seed 34
  logic [255:0] TAP_SEL;
  logic [8:0] RWB_STEPS, RWA_STEPS;
  logic [31:0] rd; // last read word
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  dpwc_if link();
  dpwc_host dpwc_host_i (.REF_CLK(REF_CLK), .RESETN(RESETN), .CE(1'b1),
    .LINK(link), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));
  dpwc_device dpwc_device_i (.REF_CLK(REF_CLK), .RESETN(RESETN),
    .CE(1'b1), .LINK(link), .WIPER_REG(WIPER_REG), .TAP_INDEX(TAP_INDEX),
    .TAP_SEL(TAP_SEL), .RWB_STEPS(RWB_STEPS), .RWA_STEPS(RWA_STEPS),
    .A_OPEN(A_OPEN), .SHUTDOWN(SHUTDOWN));
  dpwc_properties dpwc_properties_i (.REF_CLK(REF_CLK), .RESETN(RESETN),
    .sel(link.sel), .cs_n(link.cs_n), .clk(link.clk),
    .dev_sda_oe_n(link.dev_sda_oe_n), .WIPER_REG(WIPER_REG),
    .TAP_INDEX(TAP_INDEX), .TAP_SEL(TAP_SEL), .RWB_STEPS(RWB_STEPS),
    .RWA_STEPS(RWA_STEPS), .A_OPEN(A_OPEN), .SHUTDOWN(SHUTDOWN));
  // 200 MHz reference clock
  always #2.5 REF_CLK = ~REF_CLK;
  // hang guard: about three and a half times the length of the planned frames
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      final_report();
    end
  end
  // ==========================================================
  // helpers
  task final_report;
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  // one APB transfer; holds the request until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  // configure, start, poll busy; leaves status in rd, then lets
  // the device's synchroniser and output stages settle
  task frame(input logic [1:0] cfg, input logic [31:0] ctrl);
    apb(1'b1, 8'h04, {30'h0, cfg});
    apb(1'b1, 8'h00, ctrl);
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, 8'h08, 32'h0);
    repeat (12) @(posedge REF_CLK);
  endtask : frame
  task spi(input logic [7:0] c);
    frame(2'b00, {16'h0, c, 8'h01});
    check(WIPER_REG, c);
    check(TAP_INDEX, c);
    check(RWB_STEPS, {1'b0, c});
    check(RWA_STEPS, 9'h100 - c);
  endtask : spi
  // ==========================================================
  // main sequence: three-wire first, then two-wire only, so a
  // low address pin never looks like a chip select rise
  initial begin
    repeat (2) @(posedge REF_CLK);
    RESETN <= 1'b1;
    @(posedge REF_CLK);
    check(WIPER_REG, 8'h80);
    check(SHUTDOWN, 1'b0);
    spi(8'h00);
    spi(8'hFF);
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr(lfsr_q);
      spi(lfsr_q);
    end
    for (int i = 0; i < 12; i++) begin
      lfsr_q = lfsr(lfsr_q);
      code = lfsr(lfsr_q);
      // corner instructions first: reset plus shutdown, shutdown
      // alone, ignored bits only; then random
      ins = (i == 0) ? 8'h60 : (i == 1) ? 8'h20 : (i == 2) ? 8'h9F : lfsr_q;
      lfsr_q = code;
      frame({i[0], 1'b1}, {8'h0, ins, code, 8'h01});
      wexp = ins[6] ? 8'h80 : code;
      check(rd[1], 1'b0);
      check(WIPER_REG, wexp);
      check(SHUTDOWN, ins[5]);
      check(A_OPEN, ins[5]);
      check(TAP_INDEX, ins[5] ? 8'h00 : wexp);
      frame({i[0], 1'b1}, 32'h3);
      check(rd[15:8], wexp);
      check(rd[1], 1'b0);
    end
    // the other address on the bus: no ack, wiper and shutdown kept
    frame(2'b01, {8'h0, 8'h20, 8'h5A, 8'h05});
    check(rd[1], 1'b1);
    check(WIPER_REG, wexp);
    check(SHUTDOWN, ins[5]);
    // an address outside the controller's map is refused
    apb(1'b0, 8'h0C, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    final_report();
  end
endmodule : digipot_serial_wiper_control_bench
`default_nettype wire
